// File: rtl/sptc_pkg.sv
// Constants for the per-port class, tag and monitor control block
package sptc_pkg;
   localparam int unsigned NPORTS     = 3;
   localparam int unsigned VID_W      = 12;
   localparam int unsigned PRIO_W     = 2;
   // Register offsets
   localparam logic [7:0]  ADDR_P1_CTL0 = 8'h10;
   localparam logic [7:0]  ADDR_P1_CTL1 = 8'h11;
   localparam logic [7:0]  ADDR_P2_CTL0 = 8'h20;
   localparam logic [7:0]  ADDR_P2_CTL1 = 8'h21;
   localparam logic [7:0]  ADDR_P3_CTL0 = 8'h30;
   localparam logic [7:0]  ADDR_P3_CTL1 = 8'h31;
   // Class and tag control fields
   localparam int unsigned BIT_STORM    = 7;
   localparam int unsigned BIT_DSCP     = 6;
   localparam int unsigned BIT_DOT1P    = 5;
   localparam int unsigned PRIO_HI      = 4;
   localparam int unsigned PRIO_LO      = 3;
   localparam int unsigned BIT_TAG_INS  = 2;
   localparam int unsigned BIT_TAG_REM  = 1;
   localparam int unsigned BIT_SPLIT4   = 0;
   // Monitor control fields
   localparam int unsigned BIT_SNIFFER  = 7;
   localparam int unsigned BIT_TX_SNIFF = 5;
   localparam logic [7:0]  CTL1_MASK    = 8'ha0;
   // Reset values
   localparam logic [7:0]  CTL0_RST     = 8'h00;
   localparam logic [7:0]  CTL1_RST     = 8'h00;
   localparam logic [7:0]  RDATA_NONE   = 8'h00;
   localparam logic [1:0]  PORT_NONE    = 2'h3;
endpackage

// File: rtl/sptc_port_ctrl.sv
// Per-port class, tag, queue split and monitor control for a three-port switch
// Overview of operation
// - One class/tag control register per port at 0x10, 0x20, 0x30, same layout.
// - Bit 7 enables broadcast storm protection for ingress on that port.
// - Bit 6 enables DiffServ priority classification of IPv4 ingress packets.
// - Bit 5 enables 802.1p priority classification of ingress packets.
// - Bits 4-3 give the default queue when classification is off or fails.
// - With both methods enabled, OR their results; this overrides port default.
// - Bit 2 on egress port adds a tag to packets that arrived untagged.
// - Tag insertion never adds a second tag to already tagged packets.
// - Inserted tag carries the ingress port's default VLAN identifier.
// - Bit 1 on egress port strips the tag from packets that arrived tagged.
// - Tag removal passes untagged packets through unchanged.
// - Bit 0 splits the egress_queue into four queues, else one queue.
// - Monitor control register per port at 0x11, 0x21, 0x31.
// - Monitor bit 7 makes the port the sniffer destination for monitored packets.
// - Class/tag control register resets to all zero, every feature off.
// - Transmit monitoring marks packets sent on the port and forwards them to sniffer.
`timescale 1ns/1ns
module sptc_port_ctrl
   import sptc_pkg::*;
(
   input  wire logic                                       clk,
   input  wire logic                                       rst,
   input  wire logic [7:0]                                 reg_addr,
   input  wire logic                                       reg_wr,
   input  wire logic [7:0]                                 reg_wdata,
   input  wire logic                                       reg_rd,
   output logic [7:0]                                      reg_rdata,
   output logic                                            reg_rvalid,
   input  wire logic                                       cls_req,
   input  wire logic [1:0]                                 cls_port,
   input  wire logic                                       cls_dscp_hit,
   input  wire logic [sptc_pkg::PRIO_W-1:0]                cls_dscp_prio,
   input  wire logic                                       cls_dot1p_hit,
   input  wire logic [sptc_pkg::PRIO_W-1:0]                cls_dot1p_prio,
   output logic                                            cls_valid,
   output logic [sptc_pkg::PRIO_W-1:0]                     cls_prio,
   input  wire logic                                       eg_req,
   input  wire logic [1:0]                                 eg_port,
   input  wire logic [1:0]                                 eg_in_port,
   input  wire logic                                       eg_was_tagged,
   input  wire logic [sptc_pkg::NPORTS-1:0][sptc_pkg::VID_W-1:0] port_pvid,
   output logic                                            eg_valid,
   output logic                                            eg_add_tag,
   output logic                                            eg_strip_tag,
   output logic [sptc_pkg::VID_W-1:0]                      eg_vid,
   output logic                                            eg_mirror,
   output logic [sptc_pkg::NPORTS-1:0]                     storm_en,
   output logic [sptc_pkg::NPORTS-1:0]                     egress_queue_split4,
   output logic [sptc_pkg::NPORTS-1:0]                     sniffer_port
);
   import sptc_pkg::*;

   typedef struct packed {
      logic [NPORTS-1:0][7:0] ctl0;
      logic [NPORTS-1:0][7:0] ctl1;
      logic [7:0]             rdata;
      logic                   rvalid;
      logic                   cvalid;
      logic [PRIO_W-1:0]      prio;
      logic                   evalid;
      logic                   add_tag;
      logic                   strip_tag;
      logic [VID_W-1:0]       vid;
      logic                   mirror;
   } sptc_state_s;

   sptc_state_s state_q;
   sptc_state_s state_d;

   // Port index 0..2 for ports 1..3, PORT_NONE when the address hits no port
   function automatic logic [1:0] sptc_port_of(input logic [7:0] a);
      unique case (a)
         ADDR_P1_CTL0, ADDR_P1_CTL1: sptc_port_of = 2'h0;
         ADDR_P2_CTL0, ADDR_P2_CTL1: sptc_port_of = 2'h1;
         ADDR_P3_CTL0, ADDR_P3_CTL1: sptc_port_of = 2'h2;
         default:                    sptc_port_of = PORT_NONE;
      endcase
   endfunction

   function automatic logic sptc_is_ctl1(input logic [7:0] a);
      sptc_is_ctl1 = (a == ADDR_P1_CTL1) || (a == ADDR_P2_CTL1) || (a == ADDR_P3_CTL1);
   endfunction

   function automatic logic sptc_port_ok(input logic [1:0] p);
      sptc_port_ok = (p != PORT_NONE);
   endfunction

   logic [1:0]        wr_port;
   logic [1:0]        rd_port;
   logic [7:0]        c_cls;
   logic [7:0]        c_eg;
   logic [PRIO_W-1:0] prio_sel;

   assign wr_port = sptc_port_of(reg_addr);
   assign rd_port = wr_port;
   assign c_cls   = sptc_port_ok(cls_port) ? state_q.ctl0[cls_port] : CTL0_RST;
   assign c_eg    = sptc_port_ok(eg_port) ? state_q.ctl0[eg_port] : CTL0_RST;

   // Only enabled methods that produced a result take part; OR when both did
   always_comb begin
      logic dscp_ok;
      logic dot1p_ok;
      dscp_ok  = c_cls[BIT_DSCP] && cls_dscp_hit;
      dot1p_ok = c_cls[BIT_DOT1P] && cls_dot1p_hit;
      if (dscp_ok || dot1p_ok) begin
         prio_sel = (dscp_ok ? cls_dscp_prio : '0) | (dot1p_ok ? cls_dot1p_prio : '0);
      end else begin
         prio_sel = c_cls[PRIO_HI:PRIO_LO];
      end
   end

   always_comb begin
      state_d = state_q;
      // Read sees the value before a write in the same cycle
      state_d.rvalid = reg_rd;
      if (reg_rd) begin
         if (!sptc_port_ok(rd_port)) begin
            state_d.rdata = RDATA_NONE;
         end else if (sptc_is_ctl1(reg_addr)) begin
            state_d.rdata = state_q.ctl1[rd_port];
         end else begin
            state_d.rdata = state_q.ctl0[rd_port];
         end
      end
      if (reg_wr && sptc_port_ok(wr_port)) begin
         if (sptc_is_ctl1(reg_addr)) begin
            state_d.ctl1[wr_port] = reg_wdata & CTL1_MASK;
         end else begin
            state_d.ctl0[wr_port] = reg_wdata;
         end
      end
      state_d.cvalid = cls_req && sptc_port_ok(cls_port);
      if (cls_req) begin
         state_d.prio = prio_sel;
      end
      state_d.evalid = eg_req && sptc_port_ok(eg_port);
      if (eg_req) begin
         state_d.add_tag   = sptc_port_ok(eg_port) && c_eg[BIT_TAG_INS] && !eg_was_tagged;
         state_d.strip_tag = sptc_port_ok(eg_port) && c_eg[BIT_TAG_REM] && eg_was_tagged;
         state_d.vid       = sptc_port_ok(eg_in_port) ? port_pvid[eg_in_port] : '0;
         state_d.mirror    = sptc_port_ok(eg_port) && state_q.ctl1[eg_port][BIT_TX_SNIFF];
      end
      if (rst) begin
         state_d.ctl0      = {NPORTS{CTL0_RST}};
         state_d.ctl1      = {NPORTS{CTL1_RST}};
         state_d.rdata     = RDATA_NONE;
         state_d.rvalid    = 1'b0;
         state_d.cvalid    = 1'b0;
         state_d.prio      = '0;
         state_d.evalid    = 1'b0;
         state_d.add_tag   = 1'b0;
         state_d.strip_tag = 1'b0;
         state_d.vid       = '0;
         state_d.mirror    = 1'b0;
      end
   end

   always_ff @(posedge clk) begin
      state_q <= state_d;
   end

   always_comb begin
      for (int i = 0; i < NPORTS; i++) begin
         storm_en[i]            = state_q.ctl0[i][BIT_STORM];
         egress_queue_split4[i] = state_q.ctl0[i][BIT_SPLIT4];
         sniffer_port[i]        = state_q.ctl1[i][BIT_SNIFFER];
      end
   end

   assign reg_rdata    = state_q.rdata;
   assign reg_rvalid   = state_q.rvalid;
   assign cls_valid    = state_q.cvalid;
   assign cls_prio     = state_q.prio;
   assign eg_valid     = state_q.evalid;
   assign eg_add_tag   = state_q.add_tag;
   assign eg_strip_tag = state_q.strip_tag;
   assign eg_vid       = state_q.vid;
   assign eg_mirror    = state_q.mirror;

   // Helper views of the configuration seen by the current request
   logic eg_ins_cfg;
   logic eg_rem_cfg;
   logic cls_no_method;
   logic cls_both;
   logic [PRIO_W-1:0] cls_or;
   logic [PRIO_W-1:0] cls_dflt;
   assign eg_ins_cfg    = c_eg[BIT_TAG_INS];
   assign eg_rem_cfg    = c_eg[BIT_TAG_REM];
   assign cls_no_method = !c_cls[BIT_DSCP] && !c_cls[BIT_DOT1P];
   assign cls_both      = c_cls[BIT_DSCP] && c_cls[BIT_DOT1P] && cls_dscp_hit && cls_dot1p_hit;
   assign cls_or        = cls_dscp_prio | cls_dot1p_prio;
   assign cls_dflt      = c_cls[PRIO_HI:PRIO_LO];
   logic dscp_res;
   logic dot1p_res;
   assign dscp_res      = c_cls[BIT_DSCP] && cls_dscp_hit;
   assign dot1p_res     = c_cls[BIT_DOT1P] && cls_dot1p_hit;

   chk_ctl0_readback: assert property (@(posedge clk) disable iff (rst)
      (reg_wr && !reg_rd && reg_addr == ADDR_P2_CTL0) ##1 (reg_rd && !reg_wr && reg_addr == ADDR_P2_CTL0)
      |=> reg_rvalid && reg_rdata == $past(reg_wdata, 2))
      else $error("ctl0 readback mismatch");
   chk_storm_follows: assert property (@(posedge clk) disable iff (rst)
      (reg_wr && reg_addr == ADDR_P1_CTL0) |=> storm_en[0] == $past(reg_wdata[BIT_STORM]))
      else $error("storm enable not taken from write");
   chk_prio_default: assert property (@(posedge clk) disable iff (rst)
      (cls_req && sptc_port_ok(cls_port) && cls_no_method) |=> cls_valid && cls_prio == $past(cls_dflt))
      else $error("default priority not used");
   chk_prio_or: assert property (@(posedge clk) disable iff (rst)
      (cls_req && sptc_port_ok(cls_port) && cls_both) |=> cls_prio == $past(cls_or))
      else $error("priority not OR of both methods");
   chk_tag_add: assert property (@(posedge clk) disable iff (rst)
      (eg_req && sptc_port_ok(eg_port) && eg_ins_cfg && !eg_was_tagged) |=> eg_valid && eg_add_tag)
      else $error("tag not added");
   chk_no_double: assert property (@(posedge clk) disable iff (rst)
      (eg_req && eg_was_tagged) |=> !eg_add_tag)
      else $error("tag added twice");
   chk_tag_vid: assert property (@(posedge clk) disable iff (rst)
      (eg_req && eg_in_port == 2'h1) |=> eg_vid == $past(port_pvid[1]))
      else $error("inserted vid wrong");
   chk_tag_strip: assert property (@(posedge clk) disable iff (rst)
      (eg_req && sptc_port_ok(eg_port) && eg_rem_cfg && eg_was_tagged) |=> eg_strip_tag)
      else $error("tag not stripped");
   chk_untag_pass: assert property (@(posedge clk) disable iff (rst)
      (eg_req && !eg_was_tagged) |=> !eg_strip_tag)
      else $error("untagged packet modified");
   chk_ctl1_sniffer: assert property (@(posedge clk) disable iff (rst)
      (reg_wr && reg_addr == ADDR_P3_CTL1) |=> sniffer_port[2] == $past(reg_wdata[BIT_SNIFFER]))
      else $error("sniffer bit not taken");
   chk_reset_clear: assert property (@(posedge clk)
      $past(rst) |-> storm_en == '0 && egress_queue_split4 == '0 && !eg_valid && !cls_valid)
      else $error("features not off after reset");
   chk_tx_mirror: assert property (@(posedge clk) disable iff (rst)
      (eg_req && eg_port == 2'h0) |=> eg_mirror == $past(state_q.ctl1[0][BIT_TX_SNIFF]))
      else $error("transmit monitoring wrong");

   // Register bus
   chk_ctl1_readback: assert property (@(posedge clk) disable iff (rst)
      (reg_wr && !reg_rd && reg_addr == ADDR_P1_CTL1) ##1 (reg_rd && !reg_wr && reg_addr == ADDR_P1_CTL1)
      |=> reg_rvalid && reg_rdata == ($past(reg_wdata, 2) & CTL1_MASK))
      else $error("ctl1 readback mismatch");
   chk_unmapped_read: assert property (@(posedge clk) disable iff (rst)
      (reg_rd && !sptc_port_ok(sptc_port_of(reg_addr))) |=> reg_rvalid && reg_rdata == RDATA_NONE)
      else $error("unmapped read not zero");
   chk_rvalid_idle: assert property (@(posedge clk) disable iff (rst)
      !reg_rd |=> !reg_rvalid)
      else $error("read valid without read");
   chk_rdata_hold: assert property (@(posedge clk) disable iff (rst)
      !reg_rd |=> $stable(reg_rdata))
      else $error("read data changed without read");

   // Follow and hold checks catch a write that is lost or lands on the wrong port or field
   chk_storm_hold: assert property (@(posedge clk) disable iff (rst)
      !(reg_wr && reg_addr == ADDR_P1_CTL0) |=> $stable(storm_en[0]))
      else $error("storm enable changed without write");
   chk_split_follows: assert property (@(posedge clk) disable iff (rst)
      (reg_wr && reg_addr == ADDR_P2_CTL0) |=> egress_queue_split4[1] == $past(reg_wdata[BIT_SPLIT4]))
      else $error("queue split not taken from write");
   chk_split_hold: assert property (@(posedge clk) disable iff (rst)
      !(reg_wr && reg_addr == ADDR_P3_CTL0) |=> $stable(egress_queue_split4[2]))
      else $error("queue split changed without write");
   chk_sniffer_hold: assert property (@(posedge clk) disable iff (rst)
      !(reg_wr && reg_addr == ADDR_P1_CTL1) |=> $stable(sniffer_port[0]))
      else $error("sniffer bit changed without write");

   // Priority checks split by which enabled method produced a result
   chk_dscp_only: assert property (@(posedge clk) disable iff (rst)
      (cls_req && sptc_port_ok(cls_port) && dscp_res && !dot1p_res) |=> cls_prio == $past(cls_dscp_prio))
      else $error("diffserv priority not used");
   chk_dscp_off: assert property (@(posedge clk) disable iff (rst)
      (cls_req && sptc_port_ok(cls_port) && !c_cls[BIT_DSCP] && !dot1p_res) |=> cls_prio == $past(cls_dflt))
      else $error("diffserv used while disabled");
   chk_dot1p_only: assert property (@(posedge clk) disable iff (rst)
      (cls_req && sptc_port_ok(cls_port) && dot1p_res && !dscp_res) |=> cls_prio == $past(cls_dot1p_prio))
      else $error("user priority not used");
   chk_dot1p_off: assert property (@(posedge clk) disable iff (rst)
      (cls_req && sptc_port_ok(cls_port) && !c_cls[BIT_DOT1P] && !dscp_res) |=> cls_prio == $past(cls_dflt))
      else $error("user priority used while disabled");
   chk_no_hit: assert property (@(posedge clk) disable iff (rst)
      (cls_req && sptc_port_ok(cls_port) && !cls_dscp_hit && !cls_dot1p_hit) |=> cls_valid && cls_prio == $past(cls_dflt))
      else $error("default priority not used without result");
   chk_cls_idle: assert property (@(posedge clk) disable iff (rst)
      !(cls_req && sptc_port_ok(cls_port)) |=> !cls_valid)
      else $error("classification valid without request");

   // Egress checks
   chk_add_off: assert property (@(posedge clk) disable iff (rst)
      (eg_req && !eg_ins_cfg) |=> !eg_add_tag)
      else $error("tag added while insertion off");
   chk_strip_off: assert property (@(posedge clk) disable iff (rst)
      (eg_req && !eg_rem_cfg) |=> !eg_strip_tag)
      else $error("tag stripped while removal off");
   chk_eg_idle: assert property (@(posedge clk) disable iff (rst)
      !(eg_req && sptc_port_ok(eg_port)) |=> !eg_valid)
      else $error("egress valid without request");
   chk_vid_any: assert property (@(posedge clk) disable iff (rst)
      (eg_req && sptc_port_ok(eg_in_port)) |=> eg_vid == $past(port_pvid[eg_in_port]))
      else $error("inserted vid not from ingress port");
   chk_mirror_p3: assert property (@(posedge clk) disable iff (rst)
      (eg_req && eg_port == 2'h2) |=> eg_mirror == $past(state_q.ctl1[2][BIT_TX_SNIFF]))
      else $error("transmit monitoring wrong on third port");

   cov_both_methods: cover property (@(posedge clk) disable iff (rst) cls_req && cls_both);
   cov_insert: cover property (@(posedge clk) disable iff (rst) eg_valid && eg_add_tag);
   cov_strip: cover property (@(posedge clk) disable iff (rst) eg_valid && eg_strip_tag);
   cov_mirror: cover property (@(posedge clk) disable iff (rst) eg_valid && eg_mirror && |sniffer_port);
   cov_refused_cls: cover property (@(posedge clk) disable iff (rst) cls_req && !sptc_port_ok(cls_port));
endmodule

// File: test/sptc_port_ctrl_tb.sv
// Random and corner-case bench for the per-port class, tag and monitor control block
`timescale 1ns/1ns
module sptc_port_ctrl_tb;
   import sptc_pkg::*;
   logic                         clk, rst, reg_wr, reg_rd, reg_rvalid;
   logic [7:0]                   reg_addr, reg_wdata, reg_rdata;
   logic                         cls_req, cls_dscp_hit, cls_dot1p_hit, cls_valid;
   logic [1:0]                   cls_port, cls_dscp_prio, cls_dot1p_prio, cls_prio;
   logic                         eg_req, eg_was_tagged, eg_valid, eg_add_tag, eg_strip_tag, eg_mirror;
   logic [1:0]                   eg_port, eg_in_port;
   logic [NPORTS-1:0][VID_W-1:0] port_pvid;
   logic [VID_W-1:0]             eg_vid;
   logic [NPORTS-1:0]            storm_en, egress_queue_split4, sniffer_port;
   logic [7:0]                   c0 [3];
   logic [7:0]                   c1 [3];
   logic [31:0]                  seed = 32'h249f;
   logic [31:0]                  r;
   int                           n_mismatch = 0;
   int                           n_compared = 0;

   sptc_port_ctrl u_sptc_port_ctrl (.clk, .rst, .reg_addr, .reg_wr, .reg_wdata, .reg_rd, .reg_rdata, .reg_rvalid,
      .cls_req, .cls_port, .cls_dscp_hit, .cls_dscp_prio, .cls_dot1p_hit, .cls_dot1p_prio, .cls_valid, .cls_prio,
      .eg_req, .eg_port, .eg_in_port, .eg_was_tagged, .port_pvid, .eg_valid, .eg_add_tag, .eg_strip_tag, .eg_vid,
      .eg_mirror, .storm_en, .egress_queue_split4, .sniffer_port);

   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   function automatic logic [7:0] addr_of(input int i);
      return 8'(8'h10 * (i / 2 + 1) + i % 2);
   endfunction
   function automatic bit is_map(input logic [7:0] a);
      return a[7:6] == 2'd0 && a[3:1] == 3'd0 && a[5:4] != 2'd0;
   endfunction
   task automatic end_of_test();
      $display("compared %0d, mismatches %0d", n_compared, n_mismatch);
      if (n_mismatch == 0 && n_compared > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask
   task automatic tick();
      @(posedge clk);
      #1;
   endtask
   task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
      n_compared++;
      if (got !== exp) begin
         n_mismatch++;
         $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask
   // Strobes stay high between back-to-back calls; each task sets all four at once
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      reg_addr = a;
      reg_wdata = d;
      {reg_wr, reg_rd, cls_req, eg_req} = 4'b1000;
      tick();
      if (is_map(a) && a[0]) c1[a[5:4] - 2'd1] = d & CTL1_MASK;
      if (is_map(a) && !a[0]) c0[a[5:4] - 2'd1] = d;
      chk(storm_en, {c0[2][BIT_STORM], c0[1][BIT_STORM], c0[0][BIT_STORM]}, "storm");
      chk(egress_queue_split4, {c0[2][BIT_SPLIT4], c0[1][BIT_SPLIT4], c0[0][BIT_SPLIT4]}, "split");
      chk(sniffer_port, {c1[2][BIT_SNIFFER], c1[1][BIT_SNIFFER], c1[0][BIT_SNIFFER]}, "sniffer");
   endtask
   task automatic rd(input logic [7:0] a);
      reg_addr = a;
      {reg_wr, reg_rd, cls_req, eg_req} = 4'b0100;
      tick();
      chk(reg_rvalid, 1'b1, "rvalid");
      chk(reg_rdata, !is_map(a) ? RDATA_NONE : a[0] ? c1[a[5:4] - 2'd1] : c0[a[5:4] - 2'd1], "rdata");
   endtask
   task automatic cls(input logic [1:0] p, input logic [7:0] v);
      logic [1:0] e;
      logic       any;
      {cls_dot1p_prio, cls_dot1p_hit, cls_dscp_prio, cls_dscp_hit} = v[5:0];
      cls_port = p;
      {reg_wr, reg_rd, cls_req, eg_req} = 4'b0010;
      e = (p != 2'd3 && c0[p][BIT_DSCP] && v[0]) ? v[2:1] : 2'd0;
      any = p != 2'd3 && c0[p][BIT_DSCP] && v[0];
      if (p != 2'd3 && c0[p][BIT_DOT1P] && v[3]) e |= v[5:4];
      any |= p != 2'd3 && c0[p][BIT_DOT1P] && v[3];
      tick();
      chk(cls_valid, p != 2'd3, "cls_valid");
      if (p != 2'd3) chk(cls_prio, any ? e : c0[p][PRIO_HI:PRIO_LO], "cls_prio");
   endtask
   task automatic egr(input logic [1:0] p, input logic [1:0] ip, input logic t);
      {eg_port, eg_in_port, eg_was_tagged} = {p, ip, t};
      {reg_wr, reg_rd, cls_req, eg_req} = 4'b0001;
      tick();
      chk(eg_valid, p != 2'd3, "eg_valid");
      if (p != 2'd3) begin
         chk(eg_add_tag, c0[p][BIT_TAG_INS] && !t, "add");
         chk(eg_strip_tag, c0[p][BIT_TAG_REM] && t, "strip");
         chk(eg_vid, ip == 2'd3 ? 12'h000 : port_pvid[ip], "vid");
         chk(eg_mirror, c1[p][BIT_TX_SNIFF], "mirror");
      end
   endtask

   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   initial begin
      #100000;
      n_mismatch++;
      end_of_test();
   end
   initial begin
      {reg_wr, reg_rd, cls_req, eg_req, reg_addr, reg_wdata} = '0;
      {cls_port, cls_dscp_hit, cls_dscp_prio, cls_dot1p_hit, cls_dot1p_prio} = '0;
      {eg_port, eg_in_port, eg_was_tagged, port_pvid} = '0;
      c0 = '{default: CTL0_RST};
      c1 = '{default: CTL1_RST};
      rst = 1'b1;
      repeat (16) @(posedge clk);
      #1;
      rst = 1'b0;
      for (int i = 0; i < 6; i++) rd(addr_of(i));
      rd(8'h12);
      rd(8'h00);
      $display("test reset values done");
      for (int i = 0; i < 6; i++) wr(addr_of(i), 8'hff);
      for (int i = 0; i < 6; i++) rd(addr_of(i));
      // Write to unmapped 0x22 is ignored, then 0x5a on port 2 control turns the four-queue split off
      wr(8'h22, 8'h7f);
      wr(8'h20, 8'h5a);
      rd(8'h20);
      wr(8'h11, 8'hff);
      rd(8'h11);
      for (int i = 0; i < 48; i++) begin
         r = rnd();
         if (r[31]) wr(r[2:0] < 3'd6 ? addr_of(r[2:0]) : r[15:8], r[23:16] & (r[2:0] < 3'd6 ? 8'hff : 8'h7f));
         else rd(r[2:0] < 3'd6 ? addr_of(r[2:0]) : r[15:8]);
      end
      $display("test register access done");
      {reg_wr, reg_rd, cls_req, eg_req} = 4'b0000;
      rst = 1'b1;
      repeat (2) tick();
      rst = 1'b0;
      c0 = '{default: CTL0_RST};
      c1 = '{default: CTL1_RST};
      chk(storm_en | egress_queue_split4 | sniffer_port, 3'h0, "reset outputs");
      for (int i = 0; i < 6; i++) rd(addr_of(i));
      $display("test mid-run reset done");
      // Both methods on, default 3: no hits falls back, hits 1 and 2 combine to 3
      wr(8'h10, 8'h78);
      cls(2'd0, 8'h00);
      cls(2'd0, 8'h2b);
      for (int i = 0; i < 64; i++) begin
         r = rnd();
         if (r[31:30] == 2'd0) wr(addr_of(2 * (r[9:8] % 3)), r[23:16]);
         else cls(r[9:8], r[7:0]);
      end
      $display("test classification done");
      // Write to unmapped register 194 is ignored; tag insertion depends on bit 2 of the egress port's control and on the packet arriving untagged
      wr(8'hc2, 8'h3f);
      for (int i = 0; i < 64; i++) begin
         r = rnd();
         port_pvid = 36'({rnd(), rnd()});
         if (r[31:29] == 3'd0) wr(addr_of(r[10:8] % 6), r[23:16]);
         else egr(r[1:0], r[3:2], r[4]);
      end
      $display("test egress tagging done");
      {reg_wr, reg_rd, cls_req, eg_req} = 4'b0000;
      tick();
      end_of_test();
   end
endmodule
